// file: logic/sbcpc_pin_ctrl.sv
// pin-level control logic of the system basis chip toward its host
`timescale 1ns/10ps
module sbcpc_pin_ctrl
	import sbcpc_pkg::*;
#(
	parameter int IGN_DEB_CYCLES  = IGN_DEB_CYC,
	parameter int RST_HOLD_CYCLES = RST_HOLD_CYC
) (
	input  wire logic              clk_sys_i,
	input  wire logic              nrst_i,
	input  wire logic              bus_recessive_i,
	input  wire logic              xcvr_enable_i,
	input  wire logic              sleep_mode_i,
	input  wire logic              ignition_wake_in_i,
	input  wire logic              bus_wake_i,
	input  wire logic              overtemp_i,
	input  wire logic              reg_undervoltage_i,
	input  wire logic              wd_window_fail_i,
	input  wire logic              wd_trigger_n_i,
	input  wire logic              reset_out_n_i,
	input  wire logic              divider_pin_i,
	input  wire logic              div_enable_i,
	input  wire logic [3:0]        div_source_sel_i,
	input  wire logic [N_SW-1:0]   hv_switch_cmp_i,
	input  wire logic [N_SW-1:0]   switch_irq_en_i,
	input  wire logic [N_SW-1:0]   source_enable_i,
	input  wire logic [N_SW-1:0]   source_static_i,
	input  wire logic [N_SINK-1:0] sink_mode_i,
	input  wire logic [N_GATE-1:0] source_gate_in_i,
	input  wire logic              ref_fault_i,
	input  wire logic [N_EVT-1:0]  irq_src_en_i,
	input  wire logic              spi_cs_n_i,
	output logic                   rxd_o,
	output logic                   rxd_oe_o,
	output logic                   xcvr_active_o,
	output logic                   ignition_state_o,
	output logic                   wake_event_o,
	output logic                   reset_out_n_o,
	output logic                   reset_out_n_oe_o,
	output logic                   irq_out_n_o,
	output logic                   irq_out_n_oe_o,
	output logic [1:0]             irq_source_bits_o,
	output logic                   spi_frame_active_o,
	output logic                   wd_trigger_o,
	output logic                   wd_disable_bit_o,
	output logic [3:0]             div_route_o,
	output logic                   div_out_en_o,
	output logic [N_SW-1:0]        switch_state_o,
	output logic [N_SW-1:0]        source_on_o,
	output logic [N_SINK-1:0]      sink_sel_o,
	output logic                   failsafe_ref_o
);
	sbcpc_rst_state_t  rst_state_reg;
	logic [CNT_W-1:0]  rst_cnt_reg;
	logic              rst_cond;
	logic              ign_lvl;
	logic              ign_prev_reg;
	logic              trig_lvl;
	logic              trig_prev_reg;
	logic [N_GATE-1:0] gate_lvl;
	logic [N_SW-1:0]   sw_prev_reg;
	logic              sw_change;
	logic              cs_prev_reg;
	logic              frame_start;
	logic              frame_end;
	logic              pwrup_reg;
	logic [N_EVT-1:0]  events;

	// ---- receive output and transceiver gating
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rxd_o         <= 1'b1;
			rxd_oe_o      <= 1'b0;
			xcvr_active_o <= 1'b0;
		end else begin
			xcvr_active_o <= xcvr_enable_i && !sleep_mode_i;
			rxd_oe_o      <= !sleep_mode_i;
			if (xcvr_enable_i && !sleep_mode_i) begin
				rxd_o <= bus_recessive_i;
			end else begin
				rxd_o <= 1'b1;
			end
		end
	end

	// ---- ignition wake input
	sbcpc_sync_filt #(
		.STABLE_CYC (CNT_W'(IGN_DEB_CYCLES)),
		.INIT       (1'b0)
	) u_ign_filt (
		.clk_sys_i (clk_sys_i),
		.nrst_i    (nrst_i),
		.din_i     (ignition_wake_in_i),
		.level_o   (ign_lvl)
	);

	// edge driven, so a held-high ignition never keeps the chip out of sleep
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ign_prev_reg     <= 1'b0;
			ignition_state_o <= 1'b0;
			wake_event_o     <= 1'b0;
		end else begin
			ign_prev_reg     <= ign_lvl;
			ignition_state_o <= ign_lvl;
			wake_event_o     <= ign_lvl && !ign_prev_reg && sleep_mode_i;
		end
	end

	// ---- reset output sequencer
	assign rst_cond = reg_undervoltage_i || wd_window_fail_i;

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_state_reg <= RST_HOLD;
			rst_cnt_reg   <= CNT_W'(RST_HOLD_CYCLES - 1);
		end else begin
			case (rst_state_reg)
				RST_LOW: begin
					if (!rst_cond) begin
						rst_state_reg <= RST_HOLD;
						rst_cnt_reg   <= CNT_W'(RST_HOLD_CYCLES - 1);
					end
				end
				RST_HOLD: begin
					if (rst_cond) begin
						rst_state_reg <= RST_LOW;
					end else if (rst_cnt_reg == '0) begin
						rst_state_reg <= RST_RUN;
					end else begin
						rst_cnt_reg <= rst_cnt_reg - 20'h00001;
					end
				end
				default: begin
					if (rst_cond) begin
						rst_state_reg <= RST_LOW;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			reset_out_n_o    <= 1'b0;
			reset_out_n_oe_o <= 1'b1;
		end else begin
			reset_out_n_o    <= 1'b0;
			reset_out_n_oe_o <= rst_cond || rst_state_reg != RST_RUN;
		end
	end

	// ---- watchdog disable strap, sampled while reset is driven low
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wd_disable_bit_o <= 1'b0;
		end else if (reset_out_n_oe_o) begin
			wd_disable_bit_o <= divider_pin_i;
		end
	end

	// ---- watchdog trigger, filtered against short glitches
	sbcpc_sync_filt #(
		.STABLE_CYC (CNT_W'(TRIG_MIN_CYC)),
		.INIT       (1'b1)
	) u_trig_filt (
		.clk_sys_i (clk_sys_i),
		.nrst_i    (nrst_i),
		.din_i     (wd_trigger_n_i),
		.level_o   (trig_lvl)
	);

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			trig_prev_reg <= 1'b1;
			wd_trigger_o  <= 1'b0;
		end else begin
			trig_prev_reg <= trig_lvl;
			wd_trigger_o  <= trig_prev_reg && !trig_lvl;
		end
	end

	// ---- divider output routing; the pin is an input while reset is low
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			div_route_o  <= DIV_SRC_BATT;
			div_out_en_o <= 1'b0;
		end else begin
			div_route_o  <= (div_source_sel_i > DIV_SRC_LAST) ? DIV_SRC_BATT : div_source_sel_i;
			div_out_en_o <= div_enable_i && !sleep_mode_i && !reset_out_n_oe_o;
		end
	end

	// ---- switch inputs and current sources
	// first cycle after reset only loads the history, so a high switch is no false change
	assign sw_change = |((hv_switch_cmp_i ^ sw_prev_reg) & switch_irq_en_i) && !sleep_mode_i &&
		!pwrup_reg;

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sw_prev_reg    <= '0;
			switch_state_o <= '0;
		end else begin
			sw_prev_reg    <= hv_switch_cmp_i;
			switch_state_o <= hv_switch_cmp_i;
		end
	end

	genvar g;
	generate
		for (g = 0; g < N_GATE; g++) begin : gen_gate
			sbcpc_sync_filt #(
				.STABLE_CYC (20'h00001),
				.INIT       (1'b0)
			) u_gate_sync (
				.clk_sys_i (clk_sys_i),
				.nrst_i    (nrst_i),
				.din_i     (source_gate_in_i[g]),
				.level_o   (gate_lvl[g])
			);
		end
		for (g = 0; g < N_SW; g++) begin : gen_src
			always_ff @(posedge clk_sys_i or negedge nrst_i) begin
				if (!nrst_i) begin
					source_on_o[g] <= 1'b0;
				end else begin
					source_on_o[g] <= source_enable_i[g] && !sleep_mode_i &&
						(source_static_i[g] || gate_lvl[sbcpc_gate_of(g)]);
				end
			end
		end
	endgenerate

	// only three pins have a sink stage, so the mode vector is three wide
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sink_sel_o     <= '0;
			failsafe_ref_o <= 1'b0;
		end else begin
			sink_sel_o     <= sink_mode_i;
			failsafe_ref_o <= ref_fault_i;
		end
	end

	// ---- serial frame framing, gated until the reset pin is really high
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cs_prev_reg        <= 1'b1;
			spi_frame_active_o <= 1'b0;
			pwrup_reg          <= 1'b1;
		end else begin
			cs_prev_reg <= spi_cs_n_i;
			pwrup_reg   <= 1'b0;
			if (frame_start) begin
				spi_frame_active_o <= 1'b1;
			end else if (frame_end) begin
				spi_frame_active_o <= 1'b0;
			end
		end
	end

	assign frame_start = cs_prev_reg && !spi_cs_n_i && reset_out_n_i && !reset_out_n_oe_o;
	assign frame_end   = !cs_prev_reg && spi_cs_n_i && spi_frame_active_o;

	// ---- interrupt sources
	assign events = irq_src_en_i & {bus_wake_i, wake_event_o, sw_change, overtemp_i, pwrup_reg};

	sbcpc_irq_ctrl u_irq (
		.clk_sys_i         (clk_sys_i),
		.nrst_i            (nrst_i),
		.event_i           (events),
		.frame_start_i     (frame_start),
		.frame_end_i       (frame_end),
		.irq_out_n_oe_o    (irq_out_n_oe_o),
		.irq_source_bits_o (irq_source_bits_o)
	);

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq_out_n_o <= 1'b0;
		end else begin
			irq_out_n_o <= 1'b0;
		end
	end

	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);

	rxd_follow_a: assert property (
		(xcvr_enable_i && !sleep_mode_i) |=> rxd_o == $past(bus_recessive_i)
	) else $error("receive output does not follow the bus");
	rxd_idle_a: assert property (
		!xcvr_enable_i |=> rxd_o
	) else $error("receive output not high while disabled");
	rxd_sleep_a: assert property (
		sleep_mode_i |=> !rxd_oe_o && !xcvr_active_o
	) else $error("receive output driven in sleep");
	ign_wake_a: assert property (
		wake_event_o |-> $past(ign_lvl) && !$past(ign_prev_reg) && $past(sleep_mode_i)
	) else $error("wake without a rising ignition edge in sleep");
	rst_assert_a: assert property (
		rst_cond |=> reset_out_n_oe_o [*2]
	) else $error("reset output not low on fault");
	rst_hold_a: assert property (
		$fell(reset_out_n_oe_o) |-> $past(rst_state_reg == RST_HOLD && rst_cnt_reg == '0, 2)
	) else $error("reset released before the hold time");
	strap_sample_a: assert property (
		reset_out_n_oe_o |=> wd_disable_bit_o == $past(divider_pin_i)
	) else $error("strap not sampled during reset");
	strap_keep_a: assert property (
		!reset_out_n_oe_o |=> $stable(wd_disable_bit_o)
	) else $error("watchdog disable moved after reset");
	trig_edge_a: assert property (
		(trig_prev_reg && !trig_lvl) |=> wd_trigger_o ##1 !wd_trigger_o
	) else $error("trigger edge not turned into one pulse");
	div_sleep_a: assert property (
		sleep_mode_i |=> !div_out_en_o
	) else $error("divider output active in sleep");
	spi_gate_a: assert property (
		reset_out_n_oe_o |=> !$rose(spi_frame_active_o)
	) else $error("frame accepted while reset low");
endmodule

// file: logic/sbcpc_pkg.sv
// shared constants for the pin control logic
package sbcpc_pkg;
	localparam int          CLK_MHZ       = 200;
	localparam int          IGN_DEB_US    = 160;
	localparam int          IGN_DEB_CYC   = IGN_DEB_US * CLK_MHZ;
	localparam int          RST_HOLD_MS   = 4;
	localparam int          RST_HOLD_CYC  = RST_HOLD_MS * 1000 * CLK_MHZ;
	localparam int          TRIG_MIN_NS   = 1000;
	localparam int          TRIG_MIN_CYC  = (TRIG_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int          CNT_W         = 20;
	localparam int          N_SW          = 8;
	localparam int          N_SINK        = 3;
	localparam int          N_GATE        = 3;
	localparam int          N_EVT         = 5;
	localparam int          EVT_PWRUP     = 0;
	localparam int          EVT_OVERTEMP  = 1;
	localparam int          EVT_SWITCH    = 2;
	localparam int          EVT_IGN_WAKE  = 3;
	localparam int          EVT_BUS_WAKE  = 4;
	localparam logic [1:0]  CODE_BUS_WAKE = 2'h3;
	localparam logic [1:0]  CODE_IGN_WAKE = 2'h2;
	localparam logic [1:0]  CODE_SWITCH   = 2'h1;
	localparam logic [1:0]  CODE_OTHER    = 2'h0;
	localparam logic [3:0]  DIV_SRC_BATT  = 4'h0;
	localparam logic [3:0]  DIV_SRC_LAST  = 4'h8;

	typedef enum logic [1:0] {RST_LOW, RST_HOLD, RST_RUN} sbcpc_rst_state_t;

	// highest priority pending source gives the reported code
	function automatic logic [1:0] sbcpc_irq_code(input logic [N_EVT-1:0] p);
		if (p[EVT_BUS_WAKE]) begin
			return CODE_BUS_WAKE;
		end else if (p[EVT_IGN_WAKE]) begin
			return CODE_IGN_WAKE;
		end else if (p[EVT_SWITCH]) begin
			return CODE_SWITCH;
		end
		return CODE_OTHER;
	endfunction

	// current source pin to pulse gate group
	function automatic int sbcpc_gate_of(input int pin);
		return (pin < 3) ? 0 : ((pin < 6) ? 1 : 2);
	endfunction
endpackage

// file: logic/sbcpc_sync_filt.sv
// two-flop synchroniser followed by a stable-level filter
`timescale 1ns/10ps
module sbcpc_sync_filt
	import sbcpc_pkg::*;
#(
	parameter logic [CNT_W-1:0] STABLE_CYC = 20'h00001,
	parameter logic             INIT       = 1'b0
) (
	input  wire logic clk_sys_i,
	input  wire logic nrst_i,
	input  wire logic din_i,
	output logic      level_o
);
	logic             meta_reg;
	logic             sync_reg;
	logic [CNT_W-1:0] cnt_reg;

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			meta_reg <= INIT;
			sync_reg <= INIT;
		end else begin
			meta_reg <= din_i;
			sync_reg <= meta_reg;
		end
	end

	// a level shorter than STABLE_CYC never reaches the output
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			level_o <= INIT;
			cnt_reg <= '0;
		end else if (sync_reg == level_o) begin
			cnt_reg <= '0;
		end else if (cnt_reg == STABLE_CYC - 20'h00001) begin
			level_o <= sync_reg;
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_reg + 20'h00001;
		end
	end

	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);

	filt_accept_a: assert property (
		(sync_reg != level_o && cnt_reg == STABLE_CYC - 20'h00001) |=> level_o == $past(sync_reg)
	) else $error("filter did not accept a stable level");
	filt_reject_a: assert property (
		$changed(level_o) |-> $past(cnt_reg) == STABLE_CYC - 20'h00001
	) else $error("filter output moved before the stable time");
endmodule

// file: logic/sbcpc_irq_ctrl.sv
// sticky interrupt sources, source report and release at frame end
`timescale 1ns/10ps
module sbcpc_irq_ctrl
	import sbcpc_pkg::*;
(
	input  wire logic             clk_sys_i,
	input  wire logic             nrst_i,
	input  wire logic [N_EVT-1:0] event_i,
	input  wire logic             frame_start_i,
	input  wire logic             frame_end_i,
	output logic                  irq_out_n_oe_o,
	output logic      [1:0]       irq_source_bits_o
);
	logic [N_EVT-1:0] pending_reg;
	logic [N_EVT-1:0] pending_next;
	logic [N_EVT-1:0] reported_reg;

	// a new event in the clearing cycle stays pending
	always_comb begin
		pending_next = pending_reg | event_i;
		if (frame_end_i) begin
			pending_next = (pending_reg & ~reported_reg) | event_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pending_reg    <= '0;
			irq_out_n_oe_o <= 1'b0;
		end else begin
			pending_reg    <= pending_next;
			irq_out_n_oe_o <= |pending_next;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			reported_reg      <= '0;
			irq_source_bits_o <= CODE_OTHER;
		end else if (frame_start_i) begin
			reported_reg      <= pending_reg;
			irq_source_bits_o <= sbcpc_irq_code(pending_reg);
		end else if (frame_end_i) begin
			reported_reg <= '0;
		end
	end

	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);

	irq_raise_a: assert property (
		|event_i |=> irq_out_n_oe_o
	) else $error("event did not pull the interrupt low");
	irq_hold_a: assert property (
		(pending_reg != '0 && !frame_end_i) |=> irq_out_n_oe_o
	) else $error("interrupt released before the frame ended");
	irq_release_a: assert property (
		(frame_end_i && event_i == '0 && (pending_reg & ~reported_reg) == '0) |=> !irq_out_n_oe_o
	) else $error("interrupt not released at frame end");
endmodule

// file: verif/sbcpc_host_model.sv
// host microcontroller model: reset wire, divider strap, chip select and trigger pin
`timescale 1ns/10ps
module sbcpc_host_model #(
	parameter int RX_INVALID_CYC = 4
) (
	input  wire logic clk_sys_i,
	input  wire logic reset_out_n_oe_i,
	output logic      reset_wire_o,
	output logic      divider_pin_o,
	output logic      spi_cs_n_o,
	output logic      wd_trigger_n_o
);
	logic strap_hi;
	// open drain with pull-up: the wire is low only while the device pulls it
	assign reset_wire_o = reset_out_n_oe_i ? 1'b0 : 1'b1;
	// strap let go once reset rises; the undriven pin then reads low
	assign divider_pin_o = strap_hi & ~reset_wire_o;
	initial begin
		strap_hi = 1'b0;
		spi_cs_n_o = 1'b1;
		wd_trigger_n_o = 1'b1;
	end
	task automatic frame_begin();
		@(negedge clk_sys_i);
		spi_cs_n_o = 1'b0;
	endtask
	// one idle cycle after a frame is all that back-to-back frames need
	task automatic frame_end();
		@(negedge clk_sys_i);
		spi_cs_n_o = 1'b1;
		@(negedge clk_sys_i);
	endtask
	// a low shorter than the filter is sent only when a test wants it rejected
	task automatic trigger(input int low_cyc);
		@(negedge clk_sys_i);
		wd_trigger_n_o = 1'b0;
		repeat (low_cyc) @(negedge clk_sys_i);
		wd_trigger_n_o = 1'b1;
		repeat (300) @(negedge clk_sys_i);
	endtask
	// receive data is not looked at until this interval has passed
	task automatic wait_rx_valid();
		repeat (RX_INVALID_CYC) @(negedge clk_sys_i);
	endtask
endmodule

// file: verif/sbc_pin_control_logic_test.sv
// self-checking bench for the pin control logic
`timescale 1ns/10ps
module sbc_pin_control_logic_test;
	import sbcpc_pkg::*;
	localparam int         IGN  = 20;
	localparam int         HOLD = 50;
	localparam logic [7:0] GRP [3] = '{8'h07, 8'h38, 8'hC0};
	logic       clk_sys_i, nrst_i, bus_recessive_i, xcvr_enable_i, sleep_mode_i;
	logic       ignition_wake_in_i, bus_wake_i, overtemp_i, reg_undervoltage_i;
	logic       wd_window_fail_i, div_enable_i, ref_fault_i;
	logic       reset_out_n_i, divider_pin_i, spi_cs_n_i, wd_trigger_n_i;
	logic [3:0] div_source_sel_i, div_route_o;
	logic [7:0] hv_switch_cmp_i, switch_irq_en_i, source_enable_i, source_static_i;
	logic [2:0] sink_mode_i, source_gate_in_i, sink_sel_o;
	logic [4:0] irq_src_en_i;
	logic       rxd_o, rxd_oe_o, xcvr_active_o, ignition_state_o, wake_event_o;
	logic       reset_out_n_o, reset_out_n_oe_o, irq_out_n_o, irq_out_n_oe_o;
	logic [1:0] irq_source_bits_o;
	logic       spi_frame_active_o, wd_trigger_o, wd_disable_bit_o, div_out_en_o;
	logic [7:0] switch_state_o, source_on_o;
	logic       failsafe_ref_o;
	int         fail_count, num_checks, wake_cnt, trig_cnt, cyc_cnt;

	sbcpc_pin_ctrl #(.IGN_DEB_CYCLES(IGN), .RST_HOLD_CYCLES(HOLD)) DUT (
		.clk_sys_i, .nrst_i, .bus_recessive_i, .xcvr_enable_i, .sleep_mode_i,
		.ignition_wake_in_i, .bus_wake_i, .overtemp_i, .reg_undervoltage_i,
		.wd_window_fail_i, .wd_trigger_n_i, .reset_out_n_i, .divider_pin_i,
		.div_enable_i, .div_source_sel_i, .hv_switch_cmp_i, .switch_irq_en_i,
		.source_enable_i, .source_static_i, .sink_mode_i, .source_gate_in_i,
		.ref_fault_i, .irq_src_en_i, .spi_cs_n_i, .rxd_o, .rxd_oe_o, .xcvr_active_o,
		.ignition_state_o, .wake_event_o, .reset_out_n_o, .reset_out_n_oe_o,
		.irq_out_n_o, .irq_out_n_oe_o, .irq_source_bits_o, .spi_frame_active_o,
		.wd_trigger_o, .wd_disable_bit_o, .div_route_o, .div_out_en_o,
		.switch_state_o, .source_on_o, .sink_sel_o, .failsafe_ref_o);

	sbcpc_host_model HOST (.clk_sys_i, .reset_out_n_oe_i(reset_out_n_oe_o),
		.reset_wire_o(reset_out_n_i), .divider_pin_o(divider_pin_i),
		.spi_cs_n_o(spi_cs_n_i), .wd_trigger_n_o(wd_trigger_n_i));

	initial begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end
	// pulses are counted on every rising edge so that none slips between samples
	always @(posedge clk_sys_i) begin
		cyc_cnt++;
		if (wake_event_o === 1'b1) wake_cnt++;
		if (wd_trigger_o === 1'b1) trig_cnt++;
		if (cyc_cnt == 6000) begin
			fail_count++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask
	task automatic wait_rst_rise(output int n);
		n = 0;
		while (reset_out_n_oe_o !== 1'b0 && n < 200) begin
			cyc(1);
			n++;
		end
	endtask
	task automatic frame_chk(input logic [1:0] code);
		check("irq pending", 8'h01, 8'(irq_out_n_oe_o));
		HOST.frame_begin();
		cyc(2);
		check("frame active", 8'h01, 8'(spi_frame_active_o));
		check("irq source", 8'(code), 8'(irq_source_bits_o));
		check("irq held in frame", 8'h01, 8'(irq_out_n_oe_o));
		HOST.frame_end();
		cyc(3);
		check("irq released", 8'h00, 8'(irq_out_n_oe_o));
	endtask

	task automatic t_reset();
		int n;
		check("reset pulled", 8'h01, 8'(reset_out_n_oe_o));
		nrst_i = 1'b1;
		wait_rst_rise(n);
		check("reset hold", 8'h01, 8'(n >= HOLD && n <= HOLD + 3));
		check("reset data low", 8'h00, 8'(reset_out_n_o));
		check("irq data low", 8'h00, 8'(irq_out_n_o));
		check("wd disable open strap", 8'h00, 8'(wd_disable_bit_o));
		$display("test reset done");
	endtask
	task automatic t_irq();
		frame_chk(CODE_OTHER);
		irq_src_en_i[EVT_OVERTEMP] = 1'b0;
		overtemp_i = 1'b1;
		cyc(1);
		overtemp_i = 1'b0;
		cyc(3);
		check("masked event", 8'h00, 8'(irq_out_n_oe_o));
		irq_src_en_i = 5'h1F;
		overtemp_i = 1'b1;
		cyc(1);
		overtemp_i = 1'b0;
		cyc(2);
		frame_chk(CODE_OTHER);
		HOST.frame_begin();
		cyc(2);
		bus_wake_i = 1'b1;
		cyc(1);
		bus_wake_i = 1'b0;
		HOST.frame_end();
		cyc(3);
		check("event in frame kept", 8'h01, 8'(irq_out_n_oe_o));
		frame_chk(CODE_BUS_WAKE);
		switch_irq_en_i = 8'hFE;
		hv_switch_cmp_i = 8'h01;
		cyc(5);
		check("masked switch", 8'h00, 8'(irq_out_n_oe_o));
		switch_irq_en_i = 8'hFF;
		hv_switch_cmp_i = 8'h21;
		cyc(5);
		check("switch state", 8'h21, switch_state_o);
		frame_chk(CODE_SWITCH);
		$display("test irq done");
	endtask
	task automatic t_fault(input logic wd, input logic strap);
		int n;
		HOST.strap_hi = strap;
		reg_undervoltage_i = ~wd;
		wd_window_fail_i = wd;
		cyc(3);
		check("reset on fault", 8'h01, 8'(reset_out_n_oe_o));
		HOST.frame_begin();
		cyc(2);
		check("frame refused", 8'h00, 8'(spi_frame_active_o));
		HOST.frame_end();
		reg_undervoltage_i = 1'b0;
		wd_window_fail_i = 1'b0;
		wait_rst_rise(n);
		check("fault hold", 8'h01, 8'(n >= HOLD + 1 && n <= HOLD + 4));
		check("wd disable strap", 8'(strap), 8'(wd_disable_bit_o));
		$display("test fault done");
	endtask
	task automatic t_rxd();
		for (int k = 0; k < 8; k++) begin
			{xcvr_enable_i, sleep_mode_i, bus_recessive_i} = 3'(k);
			HOST.wait_rx_valid();
			check("rxd", 8'(bus_recessive_i || !xcvr_enable_i || sleep_mode_i),
				8'(rxd_o));
			check("rxd driven", 8'(!sleep_mode_i), 8'(rxd_oe_o));
			check("xcvr on", 8'(xcvr_enable_i && !sleep_mode_i), 8'(xcvr_active_o));
		end
		sleep_mode_i = 1'b0;
		$display("test rxd done");
	endtask
	task automatic t_ign();
		wake_cnt = 0;
		sleep_mode_i = 1'b1;
		ignition_wake_in_i = 1'b1;
		cyc(IGN / 2);
		ignition_wake_in_i = 1'b0;
		cyc(2 * IGN);
		check("glitch ignored", 8'h00, 8'(wake_cnt));
		ignition_wake_in_i = 1'b1;
		cyc(2 * IGN);
		check("ign state on", 8'h01, 8'(ignition_state_o));
		check("one wake", 8'h01, 8'(wake_cnt));
		sleep_mode_i = 1'b0;
		frame_chk(CODE_IGN_WAKE);
		ignition_wake_in_i = 1'b0;
		cyc(2 * IGN);
		check("ign state off", 8'h00, 8'(ignition_state_o));
		ignition_wake_in_i = 1'b1;
		cyc(2 * IGN);
		sleep_mode_i = 1'b1;
		cyc(2 * IGN);
		check("no wake awake or high", 8'h01, 8'(wake_cnt));
		sleep_mode_i = 1'b0;
		$display("test ignition done");
	endtask
	task automatic t_trig();
		trig_cnt = 0;
		HOST.trigger(TRIG_MIN_CYC + 50);
		check("trigger taken", 8'h01, 8'(trig_cnt));
		HOST.trigger(TRIG_MIN_CYC / 4);
		check("short low rejected", 8'h01, 8'(trig_cnt));
		$display("test trigger done");
	endtask
	task automatic t_div();
		div_enable_i = 1'b1;
		for (int s = 0; s < 10; s++) begin
			div_source_sel_i = 4'(s);
			cyc(2);
			check("div route", (s > DIV_SRC_LAST) ? 8'h00 : 8'(s), 8'(div_route_o));
			check("div driven", 8'h01, 8'(div_out_en_o));
		end
		sleep_mode_i = 1'b1;
		cyc(2);
		check("div off in sleep", 8'h00, 8'(div_out_en_o));
		sleep_mode_i = 1'b0;
		$display("test divider done");
	endtask
	task automatic t_src();
		source_enable_i = 8'hFF;
		for (int g = 0; g < 3; g++) begin
			source_gate_in_i = 3'h1 << g;
			cyc(5);
			check("gated group", GRP[g], source_on_o);
		end
		source_gate_in_i = 3'h0;
		source_static_i = 8'h81;
		source_enable_i = 8'h0F;
		sink_mode_i = 3'h5;
		ref_fault_i = 1'b1;
		cyc(5);
		check("static sources", 8'h01, source_on_o);
		check("sink modes", 8'h05, 8'(sink_sel_o));
		check("failsafe ref", 8'h01, 8'(failsafe_ref_o));
		ref_fault_i = 1'b0;
		cyc(2);
		check("ref restored", 8'h00, 8'(failsafe_ref_o));
		$display("test sources done");
	endtask

	initial begin
		{nrst_i, xcvr_enable_i, sleep_mode_i, ignition_wake_in_i, bus_wake_i} = 5'h00;
		{overtemp_i, reg_undervoltage_i, wd_window_fail_i, div_enable_i} = 4'h0;
		{ref_fault_i, div_source_sel_i, sink_mode_i, source_gate_in_i} = 11'h000;
		{hv_switch_cmp_i, source_enable_i, source_static_i} = 24'h000000;
		bus_recessive_i = 1'b1;
		switch_irq_en_i = 8'hFF;
		irq_src_en_i = 5'h1F;
		{fail_count, num_checks, wake_cnt, trig_cnt, cyc_cnt} = '0;
		cyc(12);
		t_reset();
		t_irq();
		t_fault(1'b0, 1'b1);
		t_fault(1'b1, 1'b0);
		t_rxd();
		t_ign();
		t_trig();
		t_div();
		t_src();
		tally_and_finish();
	end
endmodule
